// file: rtl/pxc_ext_ctrl.sv
// Extended control register two: modes, remote fault, crossover, high-z, auto power-down
`default_nettype none
`include "pxc_defs.svh"
module pxc_ext_ctrl
	import pxc_pkg::*;
(
	input  wire logic      clk_i,
	input  wire logic      sys_rst_i,
	input  wire pxc_addr_t reg_addr_i,
	input  wire logic      reg_wr_i,
	input  wire pxc_word_t reg_wdata_i,
	input  wire logic      reg_rd_i,
	output var  pxc_word_t reg_rdata_o,
	output var  logic      reg_rvalid_o,
	input  wire logic      remote_fault_i,
	input  wire logic      tx_active_i,
	input  wire logic      rx_active_i,
	input  wire logic      sqe_inhibit_i,
	input  wire logic      link_10_i,
	input  wire logic      cross_detect_i,
	input  wire logic      auto_crossover_enable_i,
	input  wire logic      line_transmit_positive_i,
	input  wire logic      line_transmit_negative_i,
	input  wire logic      pair_a_positive_i,
	input  wire logic      pair_a_negative_i,
	input  wire logic      pair_b_positive_i,
	input  wire logic      pair_b_negative_i,
	output var  logic      pair_a_positive_o,
	output var  logic      pair_a_negative_o,
	output var  logic      pair_a_oe_n_o,
	output var  logic      pair_b_positive_o,
	output var  logic      pair_b_negative_o,
	output var  logic      pair_b_oe_n_o,
	output var  logic      line_receive_positive_o,
	output var  logic      line_receive_negative_o,
	output var  logic      crs_o,
	output var  logic      sqe_test_en_o,
	output var  logic      tx100_power_down_o,
	output var  pxc_pairing_t pairing_o
);
	logic       auto_crossover_enable;
	logic       forced_pair_select;
	logic       line_driver_high_z;
	logic       auto_power_down;
	logic       res12;
	logic       res11;
	logic [5:0] res_lo;
	logic       pin_meta;
	logic       pin_sync;
	logic [3:0] rx_meta;
	logic [3:0] rx_sync;

	wire logic      hit;
	wire logic      wr_hit;
	wire pxc_word_t read_word;
	wire logic      drive_a;
	wire logic      drive_b;
	wire logic      next_crs;
	wire logic      next_pd;

	pxc_xover_if xo ();

	assign hit    = reg_addr_i == `PXC_REG_OFFSET;
	assign wr_hit = reg_wr_i && hit;

	// Reserved bits 12, 11 and 6:1 are stored as written, bit 10 always reads zero; the writer keeps them at default
	assign read_word = {`PXC_VAL_REPEATER,
		`PXC_VAL_SW_MODE,
		remote_fault_i,
		res12, res11, `PXC_VAL_RES_RO,
		auto_crossover_enable, forced_pair_select, line_driver_high_z,
		res_lo, auto_power_down};

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			auto_crossover_enable <= `PXC_RST_AUTO_EN;
			forced_pair_select    <= `PXC_RST_PAIR_SEL;
			line_driver_high_z    <= `PXC_RST_HIGH_Z;
			auto_power_down       <= `PXC_RST_AUTO_PD;
			{res12, res11, res_lo} <= `PXC_RST_RES_RW;
		end else if (wr_hit) begin
			auto_crossover_enable <= reg_wdata_i[`PXC_BIT_AUTO_EN];
			forced_pair_select    <= reg_wdata_i[`PXC_BIT_PAIR_SEL];
			line_driver_high_z    <= reg_wdata_i[`PXC_BIT_HIGH_Z];
			auto_power_down       <= reg_wdata_i[`PXC_BIT_AUTO_PD];
			res12  <= reg_wdata_i[`PXC_BIT_RES12];
			res11  <= reg_wdata_i[`PXC_BIT_RES11];
			res_lo <= reg_wdata_i[`PXC_BIT_RES_HI:`PXC_BIT_RES_LO];
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			reg_rdata_o  <= 16'h0000;
			reg_rvalid_o <= 1'h0;
		end else begin
			reg_rvalid_o <= reg_rd_i && hit;
			reg_rdata_o  <= (reg_rd_i && hit) ? read_word : 16'h0000;
		end
	end

	// Pin idles high through its pull-up, so reset loads one
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pin_meta <= 1'h1;
			pin_sync <= 1'h1;
			rx_meta  <= 4'h0;
			rx_sync  <= 4'h0;
		end else begin
			pin_meta <= auto_crossover_enable_i;
			pin_sync <= pin_meta;
			rx_meta  <= {pair_a_positive_i, pair_a_negative_i, pair_b_positive_i,
				pair_b_negative_i};
			rx_sync  <= rx_meta;
		end
	end

	assign xo.auto_en      = auto_crossover_enable;
	assign xo.pair_sel     = forced_pair_select;
	assign xo.pin_en       = pin_sync;
	assign xo.detect_cross = cross_detect_i;

	pxc_xover_sel u_sel (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.xo        (xo.sel)
	);

	assign drive_a  = (xo.pairing == PXC_STRAIGHT) && !line_driver_high_z;
	assign drive_b  = (xo.pairing == PXC_CROSS) && !line_driver_high_z;
	assign next_crs = tx_active_i || rx_active_i;
	assign next_pd  = auto_power_down && link_10_i;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pair_a_positive_o       <= 1'h0;
			pair_a_negative_o       <= 1'h0;
			pair_a_oe_n_o           <= 1'h1;
			pair_b_positive_o       <= 1'h0;
			pair_b_negative_o       <= 1'h0;
			pair_b_oe_n_o           <= 1'h1;
			line_receive_positive_o <= 1'h0;
			line_receive_negative_o <= 1'h0;
			crs_o                   <= 1'h0;
			sqe_test_en_o           <= 1'h1;
			tx100_power_down_o      <= 1'h0;
			pairing_o               <= PXC_STRAIGHT;
		end else begin
			pair_a_positive_o <= drive_a && line_transmit_positive_i;
			pair_a_negative_o <= drive_a && line_transmit_negative_i;
			pair_a_oe_n_o     <= !drive_a;
			pair_b_positive_o <= drive_b && line_transmit_positive_i;
			pair_b_negative_o <= drive_b && line_transmit_negative_i;
			pair_b_oe_n_o     <= !drive_b;
			line_receive_positive_o <= (xo.pairing == PXC_CROSS) ? rx_sync[3] : rx_sync[1];
			line_receive_negative_o <= (xo.pairing == PXC_CROSS) ? rx_sync[2] : rx_sync[0];
			crs_o              <= next_crs;
			sqe_test_en_o      <= !sqe_inhibit_i;
			tx100_power_down_o <= next_pd;
			pairing_o          <= xo.pairing;
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	read_modes_a: assert property (reg_rvalid_o |-> reg_rdata_o[15:14] == 2'h1
		&& reg_rdata_o[`PXC_BIT_RFAULT] == $past(remote_fault_i)) else $error("mode bits wrong");
	read_hit_a: assert property (reg_rd_i |=> reg_rvalid_o == $past(hit))
		else $error("read answer wrong");
	write_back_a: assert property (wr_hit ##1 reg_rd_i && hit && !reg_wr_i |=>
		reg_rdata_o[9:7] == $past(reg_wdata_i[9:7], 2)) else $error("write not stored");
	carrier_sense_a: assert property (tx_active_i || rx_active_i |=> crs_o)
		else $error("carrier sense missed");
	sqe_default_a: assert property (!sqe_inhibit_i |=> sqe_test_en_o)
		else $error("sqe test not enabled");
	high_z_a: assert property (line_driver_high_z |=> pair_a_oe_n_o && pair_b_oe_n_o)
		else $error("driver not released");
	tx_pair_a: assert property (!line_driver_high_z && xo.pairing == PXC_STRAIGHT
		|=> !pair_a_oe_n_o && pair_b_oe_n_o) else $error("straight pairing wrong");
	power_down_a: assert property (next_pd |=> tx100_power_down_o)
		else $error("power down missed");
	no_power_down_a: assert property (!auto_power_down |=> !tx100_power_down_o)
		else $error("spurious power down");

	// Line pin steering, carrier idle, register hold and read-only zero bit
	tx_cross_a: assert property (!line_driver_high_z && xo.pairing == PXC_CROSS
		|=> pair_a_oe_n_o && !pair_b_oe_n_o) else $error("cross pairing wrong");
	rx_straight_a: assert property (xo.pairing == PXC_STRAIGHT |=>
		line_receive_positive_o == $past(rx_sync[1])
		&& line_receive_negative_o == $past(rx_sync[0])) else $error("receive not on pair b");
	rx_cross_a: assert property (xo.pairing == PXC_CROSS |=>
		line_receive_positive_o == $past(rx_sync[3])
		&& line_receive_negative_o == $past(rx_sync[2])) else $error("receive not on pair a");
	a_drive_data_a: assert property (drive_a |=>
		pair_a_positive_o == $past(line_transmit_positive_i)
		&& pair_a_negative_o == $past(line_transmit_negative_i)) else $error("pair a data wrong");
	b_drive_data_a: assert property (drive_b |=>
		pair_b_positive_o == $past(line_transmit_positive_i)
		&& pair_b_negative_o == $past(line_transmit_negative_i)) else $error("pair b data wrong");
	crs_idle_a: assert property (!tx_active_i && !rx_active_i |=> !crs_o)
		else $error("carrier sense without activity");
	reg_hold_a: assert property (!wr_hit |=> $stable(auto_crossover_enable)
		&& $stable(forced_pair_select) && $stable(line_driver_high_z)
		&& $stable(auto_power_down)) else $error("control bits changed without write");
	ro_zero_a: assert property (reg_rvalid_o |-> reg_rdata_o[10] == 1'h0)
		else $error("reserved read-only bit set");
endmodule
`default_nettype wire

// file: rtl/pxc_defs.svh
// Offsets, field positions and reset values of the extended control register
`ifndef PXC_DEFS_SVH
`define PXC_DEFS_SVH

`define PXC_REG_OFFSET    5'h13
`define PXC_BIT_REPEATER  15
`define PXC_BIT_SW_MODE   14
`define PXC_BIT_RFAULT    13
`define PXC_BIT_RES12     12
`define PXC_BIT_RES11     11
`define PXC_BIT_RES10     10
`define PXC_BIT_AUTO_EN   9
`define PXC_BIT_PAIR_SEL  8
`define PXC_BIT_HIGH_Z    7
`define PXC_BIT_RES_HI    6
`define PXC_BIT_RES_LO    1
`define PXC_BIT_AUTO_PD   0
`define PXC_RST_AUTO_EN   1'h1
`define PXC_RST_PAIR_SEL  1'h0
`define PXC_RST_HIGH_Z    1'h0
`define PXC_RST_AUTO_PD   1'h1
`define PXC_RST_RES_RW    8'h00
`define PXC_VAL_REPEATER  1'h0
`define PXC_VAL_SW_MODE   1'h1
`define PXC_VAL_RES_RO    1'h0

`endif

// file: rtl/pxc_pkg.sv
// Types of the extended control register block
`default_nettype none
package pxc_pkg;
	typedef logic [15:0] pxc_word_t;
	typedef logic [4:0]  pxc_addr_t;
	typedef enum logic {PXC_STRAIGHT, PXC_CROSS} pxc_pairing_t;
endpackage
`default_nettype wire

// file: rtl/pxc_xover_if.sv
// Crossover control bundle between register bank and pairing selector
`default_nettype none
interface pxc_xover_if;
	import pxc_pkg::*;
	logic         auto_en;
	logic         pair_sel;
	logic         pin_en;
	logic         detect_cross;
	pxc_pairing_t pairing;
	modport ctrl (output auto_en, output pair_sel, output pin_en, output detect_cross,
		input pairing);
	modport sel  (input auto_en, input pair_sel, input pin_en, input detect_cross,
		output pairing);
endinterface
`default_nettype wire

// file: rtl/pxc_xover_sel.sv
// Pairing selector: forced, pin-disabled or automatic crossover
`default_nettype none
module pxc_xover_sel
	import pxc_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic sys_rst_i,
	pxc_xover_if.sel  xo
);
	wire logic   forced_mode;
	wire logic   pin_disabled;
	pxc_pairing_t next_pairing;

	assign forced_mode  = !xo.auto_en;
	assign pin_disabled = xo.auto_en && !xo.pin_en;

	always_comb begin
		if (forced_mode) begin
			next_pairing = xo.pair_sel ? PXC_CROSS : PXC_STRAIGHT;
		end else if (pin_disabled) begin
			next_pairing = PXC_STRAIGHT;
		end else begin
			next_pairing = xo.detect_cross ? PXC_CROSS : PXC_STRAIGHT;
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			xo.pairing <= PXC_STRAIGHT;
		end else begin
			xo.pairing <= next_pairing;
		end
	end

	forced_pair_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!xo.auto_en |=> (xo.pairing == (xo.pair_sel ? PXC_CROSS : PXC_STRAIGHT)) || $changed(xo.auto_en)
		|| $changed(xo.pair_sel)) else $error("forced pairing wrong");
	pin_straight_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(xo.auto_en && !xo.pin_en) ##1 (xo.auto_en && !xo.pin_en) |-> xo.pairing == PXC_STRAIGHT)
		else $error("pin low did not force straight");
	auto_follow_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(xo.auto_en && xo.pin_en) |=> xo.pairing == ($past(xo.detect_cross) ? PXC_CROSS : PXC_STRAIGHT))
		else $error("auto pairing ignored detector");
endmodule
`default_nettype wire

// file: verification/pxc_sta_model.sv
// Management entity model driving the register strobes
`default_nettype none
module pxc_sta_model
	import pxc_pkg::*;
(
	input  wire logic      clk_i,
	output var  pxc_addr_t reg_addr_o,
	output var  logic      reg_wr_o,
	output var  pxc_word_t reg_wdata_o,
	output var  logic      reg_rd_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		reg_addr_o = '0;
		reg_wr_o = 1'b0;
		reg_wdata_o = '0;
		reg_rd_o = 1'b0;
	end
	// One access: strobe held for one edge, then idle lines scrambled
	task automatic access(input pxc_addr_t a, input logic wr, input pxc_word_t d);
		@(negedge clk_i);
		reg_addr_o = a;
		reg_wr_o = wr;
		reg_rd_o = !wr;
		reg_wdata_o = d & 16'hE381;
		@(negedge clk_i);
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
		reg_addr_o = ~a;
		reg_wdata_o = ~d;
	endtask
	// Write, then read back at the very next edge
	task automatic write_read(input pxc_addr_t a, input pxc_word_t d);
		@(negedge clk_i);
		reg_addr_o = a;
		reg_wr_o = 1'h1;
		reg_rd_o = 1'h0;
		reg_wdata_o = d & 16'hE381;
		@(negedge clk_i);
		reg_wr_o = 1'h0;
		reg_rd_o = 1'h1;
		reg_wdata_o = ~d;
		@(negedge clk_i);
		reg_rd_o = 1'h0;
		reg_addr_o = ~a;
	endtask
endmodule
`default_nettype wire

// file: verification/tb_phy_extended_control_two.sv
// Testbench of the extended control register block
`default_nettype none
module tb_phy_extended_control_two;
	import pxc_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic      clk_i = 1'b0;
	logic      sys_rst_i = 1'b1;
	pxc_addr_t addr;
	logic      wr, rd, rvalid, rf, tx, rx, inh, l10, det, pin;
	pxc_word_t wdata, rdata, w;
	logic      [1:0] txd, pa, pb;
	wire logic [1:0] rxo, aout, bout, oe_n;
	logic      crs, sqe, pd, adr, bdr;
	logic      [10:0] r;
	pxc_pairing_t pairing, ep;
	pxc_word_t q[$];
	int        failures = 0;
	int        n_checks = 0;
	int        cyc = 0;
	initial begin
		forever #50 clk_i = ~clk_i;
	end
	pxc_sta_model sta (.clk_i(clk_i), .reg_addr_o(addr), .reg_wr_o(wr), .reg_wdata_o(wdata),
		.reg_rd_o(rd));
	pxc_ext_ctrl dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(addr), .reg_wr_i(wr),
		.reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
		.remote_fault_i(rf), .tx_active_i(tx), .rx_active_i(rx), .sqe_inhibit_i(inh),
		.link_10_i(l10), .cross_detect_i(det), .auto_crossover_enable_i(pin),
		.line_transmit_positive_i(txd[1]), .line_transmit_negative_i(txd[0]),
		.pair_a_positive_i(pa[1]), .pair_a_negative_i(pa[0]),
		.pair_b_positive_i(pb[1]), .pair_b_negative_i(pb[0]),
		.pair_a_positive_o(aout[1]), .pair_a_negative_o(aout[0]), .pair_a_oe_n_o(oe_n[1]),
		.pair_b_positive_o(bout[1]), .pair_b_negative_o(bout[0]), .pair_b_oe_n_o(oe_n[0]),
		.line_receive_positive_o(rxo[1]), .line_receive_negative_o(rxo[0]), .crs_o(crs),
		.sqe_test_en_o(sqe), .tx100_power_down_o(pd), .pairing_o(pairing));
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// Read answers compared against the oldest note
	always @(negedge clk_i) begin
		if (rvalid !== 1'b0) begin
			if (q.size() == 0) chk("rvalid", rvalid, 16'h0000);
			else chk("rdata", rdata, q.pop_front());
		end
	end
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 1000) begin
			failures++;
			tally_and_finish();
		end
	end
	initial begin
		{rf, tx, rx, inh, l10, det, pin, txd, pa, pb} = '0;
		void'($urandom(85121));
		repeat (6) @(negedge clk_i);
		sys_rst_i = 1'b0;
		q.push_back(16'h4201);
		sta.access(5'h13, 1'b0, 16'h0000);
		for (int i = 0; i < 16; i++) begin
			r = 11'($urandom);
			w = 16'($urandom);
			w[9:8] = i[3:2];
			@(negedge clk_i);
			{rf, tx, rx, inh, l10, txd[1]} = r[5:0];
			{txd[0], pa, pb} = r[10:6];
			{pin, det} = i[1:0];
			q.push_back({3'b010 | {2'b0, rf}, 3'b000, w[9:7], 6'h00, w[0]});
			if (i[0]) sta.write_read(5'h13, w);
			else begin
				sta.access(5'h13, 1'b1, w);
				sta.access(5'h13, 1'b0, 16'h0000);
			end
			sta.access(5'h12, 1'b0, 16'h0000);
			repeat (6) @(negedge clk_i);
			ep = pxc_pairing_t'(w[9] ? (pin & det) : w[8]);
			adr = !w[7] && ep == PXC_STRAIGHT;
			bdr = !w[7] && ep == PXC_CROSS;
			chk("pairing", pairing, ep);
			chk("oe_n", oe_n, {!adr, !bdr});
			chk("tx pairs", {aout, bout}, {adr ? txd : 2'b0, bdr ? txd : 2'b0});
			chk("rx", rxo, ep == PXC_STRAIGHT ? pb : pa);
			chk("crs", crs, tx | rx);
			chk("sqe", sqe, !inh);
			chk("pd", pd, w[0] & l10);
		end
		chk("notes left", 16'(q.size()), 16'h0000);
		tally_and_finish();
	end
endmodule
`default_nettype wire
